// >>> isf_cfg.svh
// Purpose: offsets, field positions and reset values of the status block
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   included by bare name
`ifndef ISF_CFG_SVH
`define ISF_CFG_SVH

// --------------------------------------------------------------------
// register byte addresses
// --------------------------------------------------------------------
`define ISF_OFF_STAT   8'h00
`define ISF_OFF_RXD    8'h04
`define ISF_OFF_TXD    8'h08
`define ISF_OFF_CTRL   8'h0c
`define ISF_OFF_INTST  8'h10
`define ISF_OFF_INTMSK 8'h14

// --------------------------------------------------------------------
// fields
// --------------------------------------------------------------------
`define ISF_BIT_TXF    0
`define ISF_BIT_RXF    1
`define ISF_BIT_DIR    2
`define ISF_BIT_START  3
`define ISF_BIT_EN     0
`define ISF_CTRL_RST   8'ha0
`define ISF_TX_IDLE    8'hff
`define ISF_LAST_BIT   3'h7

// --------------------------------------------------------------------
// interrupt events
// --------------------------------------------------------------------
`define ISF_EV_W       6
`define ISF_EV_START   0
`define ISF_EV_STOP    1
`define ISF_EV_AMATCH  2
`define ISF_EV_RXB     3
`define ISF_EV_TXD     4
`define ISF_EV_OVR     5

`endif

// >>> isf_pkg.sv
// Purpose: types of the status block
// Assumes: isf_cfg.svh gives the widths
// Notes:   none
`include "isf_cfg.svh"

package isf_pkg;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_AACK, ST_RX, ST_RACK, ST_TX, ST_TACK
  } isf_state_e;

  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
  } isf_sync_s;

  typedef struct packed {
    logic scl_p;
    logic sda_p;
    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
  } isf_det_s;

  typedef struct packed {
    isf_state_e                st;
    logic [2:0]                cnt;
    logic [7:0]                sr;
    logic                      ph;
    logic                      ack_ok;
    logic                      start_f;
    logic                      dir_f;
    logic                      rx_full;
    logic                      tx_full;
    logic [7:0]                rx_data;
    logic [7:0]                tx_data;
    logic [7:0]                ctrl;
    logic [`ISF_EV_W-1:0]      int_st;
    logic [`ISF_EV_W-1:0]      int_msk;
    logic [31:0]               prdata;
    logic                      pready;
    logic                      pslverr;
    logic                      irq;
    logic                      sda_oe;
    logic                      sda_o;
  } isf_core_s;

endpackage : isf_pkg

// >>> isf_link_if.sv
// Purpose: sampled bus levels and bus events between detector and core
// Assumes: all signals on pclk
// Notes:   events are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none

interface isf_link_if;
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  modport det  (output scl_s, sda_s, scl_rise, scl_fall, start, stop);
  modport core (input  scl_s, sda_s, scl_rise, scl_fall, start, stop);
endinterface : isf_link_if

`default_nettype wire

// >>> isf_sync.sv
// Purpose: two-stage synchroniser for the clock and data pins
// Assumes: pins are asynchronous to pclk
// Notes:   first stage feeds only the second
`timescale 1ns/1ps
`default_nettype none

module isf_sync (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [1:0] pin_in,
  output var  logic [1:0] pin_out
);
  isf_pkg::isf_sync_s q;
  isf_pkg::isf_sync_s n;

  always_comb begin
    n    = q;
    n.s1 = pin_in;
    n.s2 = q.s1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '1;
    end else begin
      q <= n;
    end
  end

  assign pin_out = q.s2;
endmodule : isf_sync

`default_nettype wire

// >>> isf_cond_det.sv
// Purpose: finds clock edges, start and stop conditions
// Assumes: inputs already synchronised
// Notes:   events lag the pins by three pclk cycles
`timescale 1ns/1ps
`default_nettype none

module isf_cond_det (
  input  wire logic    pclk,
  input  wire logic    presetn,
  input  wire logic    scl_in,
  input  wire logic    sda_in,
  isf_link_if.det      lk
);
  isf_pkg::isf_det_s q;
  isf_pkg::isf_det_s n;

  always_comb begin
    n          = q;
    n.scl_p    = scl_in;
    n.sda_p    = sda_in;
    n.scl_s    = scl_in;
    n.sda_s    = sda_in;
    n.scl_rise = scl_in & ~q.scl_p;
    n.scl_fall = ~scl_in & q.scl_p;
    // data edge while clock stays high
    n.start    = scl_in & q.scl_p & q.sda_p & ~sda_in;
    n.stop     = scl_in & q.scl_p & ~q.sda_p & sda_in;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '{scl_p: 1'b1, sda_p: 1'b1, scl_s: 1'b1, sda_s: 1'b1,
             default: 1'b0};
    end else begin
      q <= n;
    end
  end

  assign lk.scl_s    = q.scl_s;
  assign lk.sda_s    = q.sda_s;
  assign lk.scl_rise = q.scl_rise;
  assign lk.scl_fall = q.scl_fall;
  assign lk.start    = q.start;
  assign lk.stop     = q.stop;
endmodule : isf_cond_det

`default_nettype wire

// >>> isf_status_core.sv
// Purpose: two-wire slave port with start, direction and buffer flags
// Assumes: APB master on pclk, bus pins asynchronous
// Notes:   no clock stretching; scl is input only
`include "isf_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module isf_status_core (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  output var  logic        irq,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output var  logic        sda_o,
  output var  logic        sda_oe
);

  // ------------------------------------------------------------------
  // pin sampling and condition detection
  // ------------------------------------------------------------------
  logic [1:0] pins_s;

  isf_link_if lk ();

  isf_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  ({scl_i, sda_i}),
    .pin_out (pins_s)
  );

  isf_cond_det u_det (
    .pclk    (pclk),
    .presetn (presetn),
    .scl_in  (pins_s[1]),
    .sda_in  (pins_s[0]),
    .lk      (lk)
  );

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic isf_hit(input logic [7:0] a,
                                   input logic [7:0] off);
    isf_hit = (a == off);
  endfunction : isf_hit

  function automatic logic isf_mapped(input logic [7:0] a);
    isf_mapped = isf_hit(a, `ISF_OFF_STAT)  | isf_hit(a, `ISF_OFF_RXD)   |
                 isf_hit(a, `ISF_OFF_TXD)   | isf_hit(a, `ISF_OFF_CTRL)  |
                 isf_hit(a, `ISF_OFF_INTST) | isf_hit(a, `ISF_OFF_INTMSK);
  endfunction : isf_mapped

  isf_pkg::isf_core_s q;
  isf_pkg::isf_core_s n;

  logic                 setup;
  logic                 acc;
  logic                 wr;
  logic                 rd_rx;
  logic                 rd_int;
  logic                 rx_set;
  logic [7:0]           shifted;
  logic [7:0]           next_tx;
  logic [`ISF_EV_W-1:0] ev;
  logic [`ISF_EV_W-1:0] clr;

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    n       = q;
    ev      = '0;
    clr     = '0;
    rx_set  = 1'b0;
    setup   = psel & ~penable;
    acc     = psel & penable & q.pready;
    wr      = acc & pwrite & ~q.pslverr & pstrb[0];
    rd_rx   = acc & ~pwrite & isf_hit(paddr, `ISF_OFF_RXD);
    rd_int  = acc & ~pwrite & isf_hit(paddr, `ISF_OFF_INTST);
    shifted = {q.sr[6:0], lk.sda_s};
    next_tx = q.tx_full ? q.tx_data : `ISF_TX_IDLE;

    // bus side
    if (lk.start) begin
      n.start_f = 1'b1;
      n.st      = isf_pkg::ST_ADDR;
      n.cnt     = '0;
      n.ph      = 1'b0;
      n.sda_oe  = 1'b0;
      ev[`ISF_EV_START] = 1'b1;
    end else if (lk.stop) begin
      n.start_f = 1'b0;
      n.st      = isf_pkg::ST_IDLE;
      n.sda_oe  = 1'b0;
      ev[`ISF_EV_STOP] = 1'b1;
    end else if (!q.ctrl[`ISF_BIT_EN]) begin
      n.st      = isf_pkg::ST_IDLE;
      n.sda_oe  = 1'b0;
    end else begin
      unique case (q.st)
        isf_pkg::ST_IDLE: begin
          n.sda_oe = 1'b0;
        end
        isf_pkg::ST_ADDR: begin
          if (lk.scl_rise) begin
            n.sr  = shifted;
            n.cnt = q.cnt + 3'h1;
            if (q.cnt == `ISF_LAST_BIT) begin
              if (shifted[7:1] == q.ctrl[7:1]) begin
                n.dir_f = shifted[0];
                n.st    = isf_pkg::ST_AACK;
                n.ph    = 1'b0;
                ev[`ISF_EV_AMATCH] = 1'b1;
              end else begin
                n.st = isf_pkg::ST_IDLE;
              end
            end
          end
        end
        isf_pkg::ST_AACK: begin
          if (lk.scl_fall && !q.ph) begin
            n.sda_oe = 1'b1;
            n.ph     = 1'b1;
          end else if (lk.scl_fall) begin
            n.ph  = 1'b0;
            n.cnt = '0;
            if (q.dir_f) begin
              n.sr     = next_tx;
              n.sda_oe = ~next_tx[7];
              n.st     = isf_pkg::ST_TX;
            end else begin
              n.sda_oe = 1'b0;
              n.st     = isf_pkg::ST_RX;
            end
          end
        end
        isf_pkg::ST_RX: begin
          if (lk.scl_rise) begin
            n.sr  = shifted;
            n.cnt = q.cnt + 3'h1;
            if (q.cnt == `ISF_LAST_BIT) begin
              n.st = isf_pkg::ST_RACK;
              n.ph = 1'b0;
              if (q.rx_full) begin
                n.ack_ok = 1'b0;
                ev[`ISF_EV_OVR] = 1'b1;
              end else begin
                n.ack_ok  = 1'b1;
                n.rx_data = shifted;
                rx_set    = 1'b1;
                ev[`ISF_EV_RXB] = 1'b1;
              end
            end
          end
        end
        isf_pkg::ST_RACK: begin
          if (lk.scl_fall && !q.ph) begin
            n.sda_oe = q.ack_ok;
            n.ph     = 1'b1;
          end else if (lk.scl_fall) begin
            n.sda_oe = 1'b0;
            n.ph     = 1'b0;
            n.cnt    = '0;
            n.st     = isf_pkg::ST_RX;
          end
        end
        isf_pkg::ST_TX: begin
          if (lk.scl_rise) begin
            n.cnt = q.cnt + 3'h1;
            if (q.cnt == `ISF_LAST_BIT) begin
              n.st = isf_pkg::ST_TACK;
              n.ph = 1'b0;
            end
          end else if (lk.scl_fall) begin
            n.sr     = {q.sr[6:0], 1'b0};
            n.sda_oe = ~q.sr[6];
          end
        end
        isf_pkg::ST_TACK: begin
          if (lk.scl_fall && !q.ph) begin
            n.sda_oe  = 1'b0;
            n.tx_full = 1'b0;
            n.ph      = 1'b1;
            ev[`ISF_EV_TXD] = 1'b1;
          end else if (lk.scl_rise && q.ph) begin
            n.ack_ok = ~lk.sda_s;
          end else if (lk.scl_fall) begin
            n.ph  = 1'b0;
            n.cnt = '0;
            if (q.ack_ok) begin
              n.sr     = next_tx;
              n.sda_oe = ~next_tx[7];
              n.st     = isf_pkg::ST_TX;
            end else begin
              n.st     = isf_pkg::ST_IDLE;
            end
          end
        end
      endcase
    end

    // register side
    n.pready = setup;
    if (setup) begin
      n.pslverr = ~isf_mapped(paddr);
      n.prdata  = '0;
      if (isf_hit(paddr, `ISF_OFF_STAT)) begin
        n.prdata[`ISF_BIT_START] = q.start_f;
        n.prdata[`ISF_BIT_DIR]   = q.dir_f;
        n.prdata[`ISF_BIT_RXF]   = q.rx_full;
        n.prdata[`ISF_BIT_TXF]   = q.tx_full;
      end else if (isf_hit(paddr, `ISF_OFF_RXD)) begin
        n.prdata[7:0] = q.rx_data;
      end else if (isf_hit(paddr, `ISF_OFF_TXD)) begin
        n.prdata[7:0] = q.tx_data;
      end else if (isf_hit(paddr, `ISF_OFF_CTRL)) begin
        n.prdata[7:0] = q.ctrl;
      end else if (isf_hit(paddr, `ISF_OFF_INTST)) begin
        n.prdata[`ISF_EV_W-1:0] = q.int_st;
      end else if (isf_hit(paddr, `ISF_OFF_INTMSK)) begin
        n.prdata[`ISF_EV_W-1:0] = q.int_msk;
      end
    end

    // status word has no write path
    if (wr && isf_hit(paddr, `ISF_OFF_TXD)) begin
      n.tx_data = pwdata[7:0];
      n.tx_full = 1'b1;
    end
    if (wr && isf_hit(paddr, `ISF_OFF_CTRL)) begin
      n.ctrl = pwdata[7:0];
    end
    if (wr && isf_hit(paddr, `ISF_OFF_INTMSK)) begin
      n.int_msk = pwdata[`ISF_EV_W-1:0];
    end
    // a fresh byte in the same cycle keeps the flag set
    if (rd_rx) begin
      n.rx_full = rx_set;
    end else if (rx_set) begin
      n.rx_full = 1'b1;
    end
    // only bits actually returned are cleared
    if (rd_int) begin
      clr = q.prdata[`ISF_EV_W-1:0];
    end
    n.int_st = (q.int_st & ~clr) | ev;
    n.irq    = |(n.int_st & n.int_msk);
    n.sda_o  = 1'b0;
  end

  // ------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '{st: isf_pkg::ST_IDLE, ctrl: `ISF_CTRL_RST, default: '0};
    end else begin
      q <= n;
    end
  end

  assign prdata  = q.prdata;
  assign pready  = q.pready;
  assign pslverr = q.pslverr;
  assign irq     = q.irq;
  assign sda_o   = q.sda_o;
  assign sda_oe  = q.sda_oe;

endmodule : isf_status_core

`default_nettype wire

// >>> isf_mst.sv
// Purpose: two-wire bus master driving the block's pins
// Assumes: pull-up on the data line, 64 ns bit period
// Notes:   clock line stands high between frames
`timescale 1ns/1ps
`default_nettype none

module isf_mst (
  input  wire logic sda,
  output var  logic scl,
  output var  logic sda_low
);
  int gap;

  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    gap = 0;
  end

  // first start or repeated start
  task automatic start_cond();
    sda_low = 1'b0;
    #16 scl = 1'b1;
    #16 sda_low = 1'b1;
    #16 scl = 1'b0;
    #16;
  endtask : start_cond

  // gap stretches the low phase
  task automatic bit_io(input logic bv, output logic r);
    sda_low = !bv;
    #(16 + gap) scl = 1'b1;
    #16 r = sda;
    #16 scl = 1'b0;
    #16;
  endtask : bit_io

  task automatic xfer(input logic [7:0] w, input logic ack_in,
                      output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(w[i], r[i]);
    end
    bit_io(ack_in, ack);
  endtask : xfer

  task automatic stop_cond();
    sda_low = 1'b1;
    #16 scl = 1'b1;
    #16 sda_low = 1'b0;
    #32;
  endtask : stop_cond
endmodule : isf_mst

`default_nettype wire

// >>> isf_status_chk.sv
// Purpose: port checks of the status block
// Assumes: one access cycle per apb transfer
// Notes:   bound to isf_status_core
`timescale 1ns/1ps
`default_nettype none

module isf_status_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq,
  input wire logic        scl_i,
  input wire logic        sda_i,
  input wire logic        sda_o,
  input wire logic        sda_oe
);
  // ------
  // properties
  // ------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_done; psel && penable && pready; endsequence
  sequence s_rd_stat; s_done ##0 !pwrite && paddr == 8'h00; endsequence

  chk_ready_after: assert property (s_setup |=> pready)
    else $error("no ready after setup");
  chk_ready_once: assert property (pready |=> !pready)
    else $error("ready too long");
  chk_ready_cause: assert property (pready |-> $past(psel) && !$past(penable))
    else $error("ready without setup");
  chk_err_unmapped: assert property (s_done ##0 paddr > 8'h14
    |-> pslverr && prdata == 32'h0) else $error("no error on bad address");
  chk_err_mapped: assert property (s_done ##0 paddr < 8'h18
    && paddr[1:0] == 2'b00 |-> !pslverr) else $error("error on register");
  chk_stat_upper: assert property (s_rd_stat |-> prdata[31:4] == 28'h0)
    else $error("status upper bits set");
  chk_mask_off: assert property (s_done ##0 pwrite && pstrb[0]
    && paddr == 8'h14 && pwdata[5:0] == 6'h0 |=> !irq)
    else $error("irq with mask clear");
  chk_sda_level: assert property (sda_o == 1'b0)
    else $error("data driven high");
  chk_oe_scl_low: assert property ($rose(sda_oe) |-> !scl_i)
    else $error("data pulled while clock high");
  chk_oe_steady: assert property ($rose(scl_i) |=> $stable(sda_oe)[*5])
    else $error("data moved while clock high");
endmodule : isf_status_chk

bind isf_status_core isf_status_chk i_isf_status_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
  .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe));

`default_nettype wire

// >>> tb.sv
// Purpose: self-checking bench of the status block
// Assumes: apb master on pclk, bus master model on the pins
// Notes:   pull-up on the data line
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        irq, scl, sda_low, sda_o, sda_oe, err, a;
  logic [7:0]  paddr, b;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  int          n_errors, samples_checked;
  wire         sda_w = !(sda_low || sda_oe);

  isf_status_core i_isf_status_core (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe));
  isf_mst i_isf_mst (.sda(sda_w), .scl(scl), .sda_low(sda_low));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = !pclk;
  end

  // ------
  // tasks
  // ------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %0t got %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic w, input logic [7:0] ad,
                     input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    // look at ready between edges, where it has settled
    do begin
      @(negedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1) begin
      n_errors++;
      $display("FAIL %0t no ready", $time);
      complete_run();
    end
    // completing edge: request still held, answer taken here
    @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rchk(input logic [7:0] ad, input logic [31:0] e);
    apb(1'b0, ad, 32'h0);
    check(rd, e);
  endtask : rchk

  // ------
  // scenarios
  // ------
  task automatic t_reset();
    rchk(8'h00, 32'h0);
    rchk(8'h0c, 32'ha0);
    apb(1'b1, 8'h0c, 32'ha1);
    apb(1'b0, 8'h40, 32'h0);
    check({31'h0, err}, 32'h1);
    $display("reset test done");
  endtask : t_reset

  task automatic t_write();
    i_isf_mst.start_cond();
    rchk(8'h00, 32'h8);
    i_isf_mst.xfer(8'ha0, 1'b1, b, a);
    check({31'h0, a}, 32'h0);
    rchk(8'h00, 32'h8);
    apb(1'b1, 8'h00, 32'h7);
    rchk(8'h00, 32'h8);
    i_isf_mst.xfer(8'h5a, 1'b1, b, a);
    rchk(8'h00, 32'ha);
    rchk(8'h04, 32'h5a);
    rchk(8'h00, 32'h8);
    i_isf_mst.stop_cond();
    rchk(8'h00, 32'h0);
    $display("write test done");
  endtask : t_write

  task automatic t_read();
    apb(1'b1, 8'h08, 32'h3c);
    rchk(8'h00, 32'h1);
    i_isf_mst.gap = 40;
    i_isf_mst.start_cond();
    i_isf_mst.xfer(8'ha1, 1'b1, b, a);
    rchk(8'h00, 32'hd);
    i_isf_mst.xfer(8'hff, 1'b1, b, a);
    check({24'h0, b}, 32'h3c);
    rchk(8'h00, 32'hc);
    i_isf_mst.stop_cond();
    rchk(8'h00, 32'h4);
    i_isf_mst.gap = 0;
    i_isf_mst.start_cond();
    rchk(8'h00, 32'hc);
    i_isf_mst.xfer(8'ha0, 1'b1, b, a);
    rchk(8'h00, 32'h8);
    i_isf_mst.stop_cond();
    $display("read test done");
  endtask : t_read

  task automatic t_irq();
    apb(1'b0, 8'h10, 32'h0);
    apb(1'b1, 8'h14, 32'h1);
    check({31'h0, irq}, 32'h0);
    i_isf_mst.start_cond();
    check({31'h0, irq}, 32'h1);
    rchk(8'h10, 32'h1);
    @(posedge pclk);
    check({31'h0, irq}, 32'h0);
    i_isf_mst.stop_cond();
    check({31'h0, irq}, 32'h0);
    apb(1'b1, 8'h14, 32'h0);
    rchk(8'h10, 32'h2);
    $display("irq test done");
  endtask : t_irq

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    pstrb = 4'hf;
    n_errors = 0;
    samples_checked = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_write();
    t_read();
    t_irq();
    complete_run();
  end
endmodule : tb

`default_nettype wire
